/* rtl/serial_flash_spi_front_end.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_flash_spi_front_end #(
    parameter int STATUS_WRITE_CYCLES = 1000,
    parameter int PROGRAM_CYCLES = 2000,
    parameter int SECTOR_ERASE_CYCLES = 20000,
    parameter int BULK_ERASE_CYCLES = 40000,
    // Arbitrary signature value
    parameter logic [7:0] SIGNATURE = 8'h5a
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic [3:0] nv_bits,
    output logic so_data,
    output logic so_oe,
    output flash_pkg::mem_cmd_s mem_cmd,
    output logic [7:0] flash_status,
    output logic deep_sleep,
    output logic active
);
    // ==========================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_q;
    logic ln_clr;

    // Assert at once, release after two clean edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_q = rst_sync_q[1];

    // ==========================================
    // Core state
    typedef struct packed {
        logic [2:0] cs_sync;
        logic [2:0] tog_sync;
        logic [1:0] wp_sync;
        logic loaded;
        logic armed;
        logic deep;
        logic active;
        logic [7:0] sr;
        flash_pkg::op_e op;
        logic [31:0] timer;
        logic [8:0] walk;
        logic [2:0] bitc;
        logic [2:0] byte_idx;
        logic [6:0] shift;
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] wptr;
        logic [flash_pkg::PAGE_BYTES-1:0] mask;
        logic [flash_pkg::PAGE_BYTES-1:0][7:0] page;
        logic [7:0] resp;
        logic out_bit;
        flash_pkg::mem_cmd_s mem;
    } core_s;

    core_s q;
    core_s d;
    flash_pkg::link_in_s lp_q;
    flash_pkg::link_in_s lp_d;
    flash_pkg::link_out_s ln_q;
    flash_pkg::link_out_s ln_d;

    // Area guarded by the protect bits, upper sectors first
    function automatic logic guarded(input logic [2:0] bp, input logic [3:0] sec);
        if (bp == 3'h0) begin
            guarded = 1'b0;
        end else if (bp > 3'h4) begin
            guarded = 1'b1;
        end else begin
            guarded = {1'b0, sec} >= (flash_pkg::SECTOR_COUNT - (5'h01 << (bp - 3'h1)));
        end
    endfunction : guarded

    // ==========================================
    // Link side, runs on the serial clock
    // Rising edge captures one bit and flips a toggle for the core
    always_comb begin
        lp_d = lp_q;
        if (!cs_n && !ln_q.hold) begin
            lp_d.bit_val = si;
            lp_d.tog = ~lp_q.tog;
        end
    end

    always_ff @(posedge sclk or negedge rst_q) begin
        if (!rst_q) begin
            lp_q <= '0;
        end else begin
            lp_q <= lp_d;
        end
    end

    // Falling edge drives the output; out_bit is settled by then
    always_comb begin
        ln_d.hold = ~hold_n;
        ln_d.oe = hold_n;
        ln_d.so = q.out_bit;
    end

    // Deselect clears the output side at once, also ending a pause
    assign ln_clr = cs_n | ~rst_q;

    always_ff @(negedge sclk or posedge ln_clr) begin
        if (ln_clr) begin
            ln_q <= '0;
        end else begin
            ln_q <= ln_d;
        end
    end

    // ==========================================
    // Core on the reference clock
    always_comb begin
        logic [7:0] nb;
        logic [7:0] c;
        logic [7:0] slot;
        logic locked;
        nb = {q.shift, lp_q.bit_val};
        c = 8'h00;
        slot = q.addr[7:0] + q.wptr;
        locked = q.sr[flash_pkg::SWD_POS] & ~q.wp_sync[1];
        d = q;
        d.cs_sync = {q.cs_sync[1:0], cs_n};
        d.tog_sync = {q.tog_sync[1:0], lp_q.tog};
        d.wp_sync = {q.wp_sync[0], wp_n};
        d.mem = '0;
        d.active = ~q.cs_sync[1] | q.sr[flash_pkg::BUSY_POS];

        // Protect bits come back from the non-volatile store once
        if (!q.loaded) begin
            d.loaded = 1'b1;
            d.sr[flash_pkg::SWD_POS] = nv_bits[3];
            d.sr[flash_pkg::BP_MSB:flash_pkg::BP_LSB] = nv_bits[2:0];
        end

        // Internal cycle: page walk runs while the timer counts down
        if (q.sr[flash_pkg::BUSY_POS]) begin
            if (q.op == flash_pkg::OP_PROGRAM && !q.walk[8]) begin
                d.mem.we = q.mask[q.walk[7:0]];
                d.mem.addr = {q.addr[19:8], q.walk[7:0]};
                d.mem.data = q.page[q.walk[7:0]];
                d.walk = q.walk + 9'h001;
            end
            if (q.timer == 32'h0) begin
                d.sr[flash_pkg::BUSY_POS] = 1'b0;
                d.sr[flash_pkg::WEL_POS] = 1'b0;
                d.op = flash_pkg::OP_IDLE;
            end else begin
                d.timer = q.timer - 32'h1;
            end
        end

        // Select falling edge opens a frame and arms the part
        if (q.cs_sync[2] && !q.cs_sync[1]) begin
            d.armed = 1'b1;
            d.bitc = 3'h0;
            d.byte_idx = 3'h0;
        end

        // One serial bit arrived
        if ((q.tog_sync[2] ^ q.tog_sync[1]) && !q.cs_sync[1] && q.armed) begin
            d.shift = nb[6:0];
            d.bitc = q.bitc + 3'h1;
            if (q.bitc == 3'h7) begin
                c = (q.byte_idx == 3'h0) ? nb : q.cmd;
                case (q.byte_idx)
                    3'h0: begin
                        d.cmd = nb;
                        if (nb == flash_pkg::PAGE_PROGRAM_CMD && !q.sr[flash_pkg::BUSY_POS]) begin
                            d.mask = '0;
                            d.wptr = 8'h00;
                        end
                    end
                    3'h1: d.addr[23:16] = nb;
                    3'h2: d.addr[15:8] = nb;
                    3'h3: d.addr[7:0] = nb;
                    default: begin
                        // Data wraps inside the page; later bytes overwrite
                        if (q.cmd == flash_pkg::PAGE_PROGRAM_CMD && !q.sr[flash_pkg::BUSY_POS]) begin
                            d.page[slot] = nb;
                            d.mask[slot] = 1'b1;
                            d.wptr = q.wptr + 8'h01;
                        end
                    end
                endcase
                if (q.byte_idx != flash_pkg::LEN_PROGRAM_MIN) begin
                    d.byte_idx = q.byte_idx + 3'h1;
                end
                // Status is re-read every byte so polling sees updates
                if (q.deep && c != flash_pkg::WAKE_AND_SIGNATURE_CMD) begin
                    d.resp = 8'h00;
                end else if (c == flash_pkg::READ_STATUS_CMD) begin
                    d.resp = q.sr;
                end else if (c == flash_pkg::WAKE_AND_SIGNATURE_CMD
                             && q.byte_idx >= flash_pkg::SIG_AFTER_BYTE) begin
                    d.resp = SIGNATURE;
                end else begin
                    d.resp = 8'h00;
                end
                d.out_bit = d.resp[7];
            end else begin
                d.out_bit = q.resp[3'h6 - q.bitc];
            end
        end

        // Select rising edge executes whole-byte frames only
        if (q.cs_sync[1] && !q.cs_sync[2]) begin
            d.bitc = 3'h0;
            d.byte_idx = 3'h0;
            if (q.armed && q.bitc == 3'h0) begin
                if (q.deep) begin
                    if (q.cmd == flash_pkg::WAKE_AND_SIGNATURE_CMD) begin
                        d.deep = 1'b0;
                    end
                end else if (!q.sr[flash_pkg::BUSY_POS]) begin
                    case (q.cmd)
                        flash_pkg::WRITE_ENABLE_CMD: begin
                            if (q.byte_idx == flash_pkg::LEN_SHORT) begin
                                d.sr[flash_pkg::WEL_POS] = 1'b1;
                            end
                        end
                        flash_pkg::WRITE_DISABLE_CMD: begin
                            if (q.byte_idx == flash_pkg::LEN_SHORT) begin
                                d.sr[flash_pkg::WEL_POS] = 1'b0;
                            end
                        end
                        flash_pkg::STATUS_WRITE_CMD: begin
                            if (q.byte_idx == flash_pkg::LEN_STATUS_WRITE
                                && q.sr[flash_pkg::WEL_POS] && !locked) begin
                                d.sr[flash_pkg::SWD_POS] = q.addr[23];
                                d.sr[flash_pkg::BP_MSB:flash_pkg::BP_LSB] = q.addr[20:18];
                                d.sr[flash_pkg::BUSY_POS] = 1'b1;
                                d.op = flash_pkg::OP_STATUS;
                                d.timer = 32'(STATUS_WRITE_CYCLES - 1);
                            end
                        end
                        flash_pkg::PAGE_PROGRAM_CMD: begin
                            if (q.byte_idx == flash_pkg::LEN_PROGRAM_MIN
                                && q.sr[flash_pkg::WEL_POS]
                                && !guarded(q.sr[flash_pkg::BP_MSB:flash_pkg::BP_LSB],
                                            q.addr[19:16])) begin
                                d.sr[flash_pkg::BUSY_POS] = 1'b1;
                                d.op = flash_pkg::OP_PROGRAM;
                                d.walk = 9'h000;
                                d.timer = 32'(PROGRAM_CYCLES - 1);
                            end
                        end
                        flash_pkg::SECTOR_ERASE_CMD: begin
                            if (q.byte_idx == flash_pkg::LEN_SECTOR
                                && q.sr[flash_pkg::WEL_POS]
                                && !guarded(q.sr[flash_pkg::BP_MSB:flash_pkg::BP_LSB],
                                            q.addr[19:16])) begin
                                d.mem.erase_sector = 1'b1;
                                d.mem.addr = {q.addr[19:16], 16'h0000};
                                d.sr[flash_pkg::BUSY_POS] = 1'b1;
                                d.op = flash_pkg::OP_SECTOR;
                                d.timer = 32'(SECTOR_ERASE_CYCLES - 1);
                            end
                        end
                        flash_pkg::BULK_ERASE_CMD: begin
                            if (q.byte_idx == flash_pkg::LEN_SHORT
                                && q.sr[flash_pkg::WEL_POS]
                                && q.sr[flash_pkg::BP_MSB:flash_pkg::BP_LSB] == 3'h0) begin
                                d.mem.erase_all = 1'b1;
                                d.sr[flash_pkg::BUSY_POS] = 1'b1;
                                d.op = flash_pkg::OP_BULK;
                                d.timer = 32'(BULK_ERASE_CYCLES - 1);
                            end
                        end
                        flash_pkg::DEEP_SLEEP_CMD: begin
                            if (q.byte_idx == flash_pkg::LEN_SHORT) begin
                                d.deep = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            q <= '0;
            q.cs_sync <= 3'h7;
            q.sr <= flash_pkg::STATUS_RESET;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Outputs
    assign so_data = ln_q.so;
    assign so_oe = ln_q.oe;
    assign mem_cmd = q.mem;
    assign flash_status = q.sr;
    assign deep_sleep = q.deep;
    assign active = q.active;

    // ==========================================
    // Checks
    chk_wel_after_cycle: assert property (@(posedge ref_clk) disable iff (!rst_q)
        $fell(q.sr[flash_pkg::BUSY_POS]) |-> !q.sr[flash_pkg::WEL_POS])
        else $error("latch still set after cycle");
    chk_bulk_needs_clear: assert property (@(posedge ref_clk) disable iff (!rst_q)
        q.mem.erase_all |-> q.sr[flash_pkg::BP_MSB:flash_pkg::BP_LSB] == 3'h0)
        else $error("bulk erase with protect bits set");
    chk_busy_holds: assert property (@(posedge ref_clk) disable iff (!rst_q)
        $rose(q.sr[flash_pkg::BUSY_POS]) |-> q.sr[flash_pkg::BUSY_POS] [*8])
        else $error("busy dropped early");
    chk_sleep_idle: assert property (@(posedge ref_clk) disable iff (!rst_q)
        q.deep |-> !q.sr[flash_pkg::BUSY_POS] && !q.mem.we)
        else $error("work while asleep");
    chk_locked_bits: assert property (@(posedge ref_clk) disable iff (!rst_q)
        $past(q.loaded) && $past(q.sr[flash_pkg::SWD_POS] && !q.wp_sync[1])
        |-> $stable(q.sr[7:2]))
        else $error("locked bits changed");
    chk_reject_busy: assert property (@(posedge ref_clk) disable iff (!rst_q)
        q.sr[flash_pkg::BUSY_POS] && q.timer != 32'h0
        |=> q.sr[flash_pkg::BUSY_POS] && $stable(q.op))
        else $error("cycle disturbed while busy");
    chk_wait_cs_fall: assert property (@(posedge ref_clk) disable iff (!rst_q)
        !q.armed && !q.sr[flash_pkg::BUSY_POS] |=> !q.sr[flash_pkg::BUSY_POS])
        else $error("instruction before first select");
    chk_active_power: assert property (@(posedge ref_clk) disable iff (!rst_q)
        q.sr[flash_pkg::BUSY_POS] |=> q.active)
        else $error("standby during cycle");
    chk_deselect_float: assert property (@(negedge sclk) disable iff (!rst_q)
        cs_n |-> !so_oe)
        else $error("output driven while deselected");
    chk_hold_float: assert property (@(negedge sclk) disable iff (cs_n || !rst_q)
        !hold_n |=> !so_oe)
        else $error("output driven during pause");
endmodule : serial_flash_spi_front_end
`default_nettype wire

/* rtl/flash_pkg.sv */
`default_nettype none
package flash_pkg;
    // ==========================================
    // Instruction codes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hd8;
    localparam logic [7:0] BULK_ERASE_CMD = 8'hc7;
    localparam logic [7:0] DEEP_SLEEP_CMD = 8'hb9;
    localparam logic [7:0] WAKE_AND_SIGNATURE_CMD = 8'hab;
    // ==========================================
    // Frame lengths in whole bytes
    localparam logic [2:0] LEN_SHORT = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_SECTOR = 3'h4;
    localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;
    localparam logic [2:0] LEN_HEADER = 3'h4;
    localparam logic [2:0] SIG_AFTER_BYTE = 3'h3;
    // ==========================================
    // Status register fields
    localparam int BUSY_POS = 0;
    localparam int WEL_POS = 1;
    localparam int BP_LSB = 2;
    localparam int BP_MSB = 4;
    localparam int SWD_POS = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // ==========================================
    // Array geometry
    localparam int ADDR_W = 20;
    localparam int PAGE_BYTES = 256;
    localparam logic [4:0] SECTOR_COUNT = 5'h10;
    // ==========================================
    // Types
    typedef enum logic [2:0] {
        OP_IDLE = 3'b000,
        OP_STATUS = 3'b001,
        OP_PROGRAM = 3'b011,
        OP_SECTOR = 3'b010,
        OP_BULK = 3'b110
    } op_e;
    typedef struct packed {
        logic we;
        logic erase_sector;
        logic erase_all;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } mem_cmd_s;
    typedef struct packed {
        logic bit_val;
        logic tog;
    } link_in_s;
    typedef struct packed {
        logic hold;
        logic oe;
        logic so;
    } link_out_s;
endpackage : flash_pkg
`default_nettype wire

/* tb/spi_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Serial bus master stand-in
module spi_master_model (
    output logic sclk,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so_data,
    input wire logic so_oe
);
    logic mode3;
    int pause_at;
    logic paused_oe;
    // Idle levels; pause is raised only inside a frame, never outside one
    initial begin
        mode3 = 1'b0;
        pause_at = -1;
        paused_oe = 1'b0;
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // ==========================================
    // One frame of n bytes, most significant bit first both ways
    task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
        int i;
        rx = '0;
        paused_oe = 1'b0;
        #37;
        sclk <= mode3; // Park first so no clock edge meets the select edge
        #40;
        cs_n <= 1'b0;
        #40;
        for (i = 0; i < 8 * n; i++) begin
            // Optional pause between two bits, clock high on entry
            if (i == pause_at) begin
                hold_n <= 1'b0; // Only while selected
                #40;
                repeat (2) begin
                    sclk <= 1'b0; // Junk clock and data while paused
                    si <= ~si;
                    #40;
                    paused_oe = paused_oe | so_oe;
                    sclk <= 1'b1;
                    #40;
                end
                hold_n <= 1'b1;
                #40;
                sclk <= 1'b0; // Pause ends on this falling edge
                #40;
            end
            sclk <= 1'b0;
            si <= tx[63 - i];
            #80;
            sclk <= 1'b1;
            #1;
            rx[63 - i] = so_oe ? so_data : 1'bx;
            #79;
        end
        sclk <= mode3; // Clock parks at idle level
        #80;
        cs_n <= 1'b1;
        si <= ~si; // Released line must not keep its last value
        #30;
    endtask : frame
endmodule : spi_master_model
`default_nettype wire

/* tb/serial_flash_spi_front_end_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_flash_spi_front_end_tb;
    // ==========================================
    // Signals and bookkeeping
    localparam logic [7:0] SIG = 8'h3c; // Arbitrary signature value
    logic ref_clk, rst_n, wp_n, sclk, cs_n, si, hold_n, so_data, so_oe, deep_sleep, active;
    logic [3:0] nv_bits;
    logic [7:0] flash_status;
    flash_pkg::mem_cmd_s mem_cmd;
    logic [63:0] rx;
    logic [27:0] wq[$];
    logic [19:0] sec_addr, pg;
    logic [31:0] dat;
    logic [3:0] sec;
    logic [2:0] bp_s;
    int n_fail, samples_checked, n_sec, n_all, i, j, found;

    serial_flash_spi_front_end #(
        .STATUS_WRITE_CYCLES(300),
        .PROGRAM_CYCLES(2000),
        .SECTOR_ERASE_CYCLES(20),
        .BULK_ERASE_CYCLES(20),
        .SIGNATURE(SIG)
    ) serial_flash_spi_front_end_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .nv_bits(nv_bits), .so_data(so_data), .so_oe(so_oe),
        .mem_cmd(mem_cmd), .flash_status(flash_status), .deep_sleep(deep_sleep),
        .active(active)
    );
    spi_master_model spi_master_model_inst (
        .sclk(sclk), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_data(so_data), .so_oe(so_oe)
    );
    // Core clock, 200 MHz
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Array command collector
    always @(posedge ref_clk) begin
        if (mem_cmd.we === 1'b1) wq.push_back({mem_cmd.addr, mem_cmd.data});
        if (mem_cmd.erase_sector === 1'b1) begin
            n_sec++;
            sec_addr = mem_cmd.addr;
        end
        if (mem_cmd.erase_all === 1'b1) n_all++;
    end
    // ==========================================
    // Expectations
    function automatic logic [7:0] stat_exp(input logic swd, input logic [2:0] bp,
                                            input logic write_enable_latch, input logic busy);
        return {swd, 2'b00, bp, write_enable_latch, busy};
    endfunction : stat_exp
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input int n, input logic [63:0] tx);
        spi_master_model_inst.frame(n, tx, rx);
    endtask : send
    task automatic cmd1(input logic [7:0] op);
        send(1, {op, 56'h0});
    endtask : cmd1
    // Bounded wait for the internal cycle to end
    task automatic wait_idle();
        int k;
        for (k = 0; k < 5000 && flash_status[0] !== 1'b0; k++) @(posedge ref_clk);
        if (flash_status[0] !== 1'b0) n_fail++; // Stuck busy counts as a mismatch
    endtask : wait_idle
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // Watchdog well past the expected run length
    initial begin
        #400us;
        n_fail++;
        complete_run();
    end
    // ==========================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        nv_bits = 4'h0;
        n_fail = 0;
        samples_checked = 0;
        n_sec = 0;
        n_all = 0;
        void'($urandom(33859));
        bp_s = 3'($urandom_range(1, 7));
        @(posedge ref_clk) nv_bits <= {1'b0, bp_s};
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk(flash_status, stat_exp(1'b0, bp_s, 1'b0, 1'b0));
        chk(active, 1'b0);
        chk(so_oe, 1'b0);
        // Status read in both clock modes
        for (i = 0; i < 2; i++) begin
            spi_master_model_inst.mode3 = i[0];
            spi_master_model_inst.pause_at = (i == 0) ? 12 : -1; // Pause mid-answer, mode 0
            send(2, {flash_pkg::READ_STATUS_CMD, 56'h0});
            chk(rx[55:48], stat_exp(1'b0, bp_s, 1'b0, 1'b0));
            chk(so_oe, 1'b0);
            chk(spi_master_model_inst.paused_oe, 1'b0);
        end
        spi_master_model_inst.mode3 = 1'b0;
        $display("test status_read done");
        // Erase refusals: no latch, protect bits, guarded sector
        send(4, {flash_pkg::SECTOR_ERASE_CMD, 56'h0});
        chk(flash_status[0], 1'b0);
        cmd1(flash_pkg::WRITE_ENABLE_CMD);
        chk(flash_status, stat_exp(1'b0, bp_s, 1'b1, 1'b0));
        cmd1(flash_pkg::BULK_ERASE_CMD);
        send(4, {flash_pkg::SECTOR_ERASE_CMD, 8'h0f, 48'h0});
        chk(flash_status[0], 1'b0);
        cmd1(flash_pkg::WRITE_DISABLE_CMD);
        chk(flash_status[1], 1'b0);
        chk(n_sec + n_all, 0);
        $display("test erase_refusal done");
        // Hardware protected mode
        cmd1(flash_pkg::WRITE_ENABLE_CMD);
        send(2, {flash_pkg::STATUS_WRITE_CMD, 1'b1, 2'b00, bp_s, 2'b00, 48'h0});
        wait_idle();
        chk(flash_status, stat_exp(1'b1, bp_s, 1'b0, 1'b0));
        @(posedge ref_clk) wp_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cmd1(flash_pkg::WRITE_ENABLE_CMD);
        send(2, {flash_pkg::STATUS_WRITE_CMD, 56'h0});
        chk(flash_status, stat_exp(1'b1, bp_s, 1'b1, 1'b0));
        @(posedge ref_clk) wp_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        send(2, {flash_pkg::STATUS_WRITE_CMD, 56'h0});
        chk(flash_status, stat_exp(1'b0, 3'h0, 1'b1, 1'b1));
        chk(active, 1'b1);
        wait_idle();
        repeat (2) @(posedge ref_clk);
        chk(flash_status, stat_exp(1'b0, 3'h0, 1'b0, 1'b0));
        chk(active, 1'b0);
        $display("test hw_protect done");
        // Page program wrapping in its page, erase tried while busy
        pg = {12'($urandom), 8'hfe};
        dat = $urandom;
        wq.delete();
        cmd1(flash_pkg::WRITE_ENABLE_CMD);
        send(8, {flash_pkg::PAGE_PROGRAM_CMD, 4'h0, pg, dat});
        chk(flash_status[0], 1'b1);
        send(4, {flash_pkg::SECTOR_ERASE_CMD, 8'h03, 48'h0});
        wait_idle();
        chk(n_sec, 0);
        chk(wq.size(), 4);
        for (i = 0; i < 4; i++) begin
            found = 0;
            for (j = 0; j < wq.size(); j++) begin
                if (wq[j][27:8] === {pg[19:8], 8'(pg[7:0] + 8'(i))}) begin
                    found++;
                    chk(wq[j][7:0], dat[31 - 8 * i -: 8]);
                end
            end
            chk(found, 1);
        end
        chk(flash_status, stat_exp(1'b0, 3'h0, 1'b0, 1'b0));
        $display("test page_program done");
        // Sector erase at a random sector, then bulk erase
        for (i = 0; i < 2; i++) begin
            if (i == 0) sec = 4'($urandom); // Kept for the address check after the loop
            cmd1(flash_pkg::WRITE_ENABLE_CMD);
            if (i == 0) send(4, {flash_pkg::SECTOR_ERASE_CMD, 4'h0, sec, 48'h0});
            else cmd1(flash_pkg::BULK_ERASE_CMD);
            wait_idle();
            chk(flash_status, stat_exp(1'b0, 3'h0, 1'b0, 1'b0));
        end
        chk(n_sec, 1);
        chk(sec_addr, {sec, 16'h0});
        chk(n_all, 1);
        $display("test erase done");
        // Deep sleep ignores all but the wake instruction
        cmd1(flash_pkg::DEEP_SLEEP_CMD);
        chk(deep_sleep, 1'b1);
        cmd1(flash_pkg::WRITE_ENABLE_CMD);
        chk(flash_status[1], 1'b0);
        send(5, {flash_pkg::WAKE_AND_SIGNATURE_CMD, 56'h0});
        chk(rx[31:24], SIG);
        chk(deep_sleep, 1'b0);
        $display("test deep_sleep done");
        complete_run();
    end
endmodule : serial_flash_spi_front_end_tb
`default_nettype wire
